/* include/clock_control_map.svh */
`ifndef CLOCK_CONTROL_MAP_SVH
`define CLOCK_CONTROL_MAP_SVH

// apb register byte offsets
`define CCM_CPU_MODE_OFFSET 12'h000
`define CCM_MISC_OFFSET 12'h004
`define CCM_STATUS_OFFSET 12'h008
`define CCM_PRESCALER_OFFSET 12'h00c
`define CCM_TIMER_OFFSET 12'h010

// cpu mode register fields
`define CCM_CPU_SUB_EN_BIT 4
`define CCM_CPU_MAIN_STOP_BIT 5
`define CCM_CPU_SPEED_LSB 6
`define CCM_CPU_SPEED_MSB 7
`define CCM_CPU_MODE_RESET 8'h80

// misc clock control register fields
`define CCM_MISC_STAB_BIT 0
`define CCM_MISC_AUTO_EN_BIT 1
`define CCM_MISC_AUTO_WAIT_BIT 2
`define CCM_MISC_AUTO_START_BIT 3
`define CCM_MISC_RESET 8'h00

// speed field codes
`define CCM_SPEED_HIGH 2'h0
`define CCM_SPEED_LOW 2'h1
`define CCM_SPEED_MIDDLE 2'h2

// divide ratios
`define CCM_DIV_MIDDLE 4'h8
`define CCM_DIV_HALF 4'h2
`define CCM_DIV_PRESCALE 5'h10

// stop release preload values
`define CCM_PRESCALER_PRELOAD 8'hff
`define CCM_TIMER_PRELOAD 8'h01

// auto switch delay in low-speed machine cycles (midpoints of 4.5-5.5 and 6.5-7.5)
`define CCM_AUTO_WAIT_SHORT 4'h5
`define CCM_AUTO_WAIT_LONG 4'h7

`endif

/* include/clock_control_pkg.sv */
package clock_control_pkg;

    typedef enum logic [1:0] {
        run_state,
        wait_state,
        stop_state,
        release_state
    } power_state_type;

    typedef struct packed {
        logic [1:0] speed;
        logic main_stop;
        logic sub_enable;
    } cpu_mode_type;

    typedef struct packed {
        logic auto_start;
        logic auto_wait_long;
        logic auto_enable;
        logic stab_skip;
    } misc_control_type;

endpackage

/* rtl/system_clock_mode_and_power_control.sv */
// The implementer's own choices: the APB interface to the registers and the register addresses.
`include "clock_control_map.svh"

module system_clock_mode_and_power_control (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator inputs, sampled as levels
    input wire logic main_oscillator_input,
    input wire logic sub_oscillator_input,
    // cpu events
    input wire logic stop_instruction,
    input wire logic wait_instruction,
    input wire logic interrupt_accepted,
    input wire logic external_interrupt,
    // two-wire bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // clock and oscillator control
    output logic internal_clock,
    output logic main_osc_enable,
    output logic sub_osc_enable,
    output logic sub_pins_as_port
);

    clock_control_pkg::cpu_mode_type cpu_mode_register;
    clock_control_pkg::misc_control_type misc_clock_control_register;
    clock_control_pkg::power_state_type state;
    logic [7:0] prescaler;
    logic [7:0] timer;
    logic [3:0] div_count;
    logic [4:0] pre_div;
    logic scl_change;
    logic sda_change;
    logic [3:0] auto_count;
    logic auto_pending;
    logic [31:0] next_prdata;
    logic write_take;
    logic read_take;
    logic addr_ok;
    logic main_edge;
    logic sub_edge;
    logic src_edge;
    logic [3:0] div_ratio;
    logic phase_tick;
    logic low_speed;
    logic bus_edge;
    logic underflow;
    logic write_cpu_mode;
    logic write_misc;
    logic write_prescaler;
    logic write_timer;

    assign write_take = psel && penable && pwrite && pready;
    assign read_take = psel && !penable && !pwrite;
    assign low_speed = cpu_mode_register.speed == `CCM_SPEED_LOW;
    assign bus_edge = scl_change || sda_change;
    assign underflow = prescaler == 8'h00 && timer == 8'h00;
    assign write_cpu_mode = write_take && paddr == `CCM_CPU_MODE_OFFSET;
    assign write_misc = write_take && paddr == `CCM_MISC_OFFSET;
    assign write_prescaler = write_take && paddr == `CCM_PRESCALER_OFFSET;
    assign write_timer = write_take && paddr == `CCM_TIMER_OFFSET;

    always_comb begin
        addr_ok = 1'b1;
        next_prdata = 32'h00000000;
        unique case (paddr)
            `CCM_CPU_MODE_OFFSET: next_prdata[7:0] = {cpu_mode_register.speed,
                cpu_mode_register.main_stop, cpu_mode_register.sub_enable, 4'h0};
            `CCM_MISC_OFFSET: next_prdata[3:0] = misc_clock_control_register;
            `CCM_STATUS_OFFSET: next_prdata[1:0] = state;
            `CCM_PRESCALER_OFFSET: next_prdata[7:0] = prescaler;
            `CCM_TIMER_OFFSET: next_prdata[7:0] = timer;
            default: addr_ok = 1'b0;
        endcase
    end

    // apb slave: read data latched in setup, answer in access with no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (read_take) begin
                prdata <= next_prdata;
            end
        end
    end

    // cpu mode register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_mode_register <= clock_control_pkg::cpu_mode_type'(
                4'(`CCM_CPU_MODE_RESET >> `CCM_CPU_SUB_EN_BIT));
        end else if (state == clock_control_pkg::run_state && low_speed && auto_pending
                     && auto_count == 4'h0) begin
            cpu_mode_register.speed <= `CCM_SPEED_MIDDLE;
            cpu_mode_register.main_stop <= 1'b0;
        end else if (write_cpu_mode) begin
            cpu_mode_register.speed <= pwdata[`CCM_CPU_SPEED_MSB:`CCM_CPU_SPEED_LSB];
            cpu_mode_register.main_stop <= pwdata[`CCM_CPU_MAIN_STOP_BIT];
            cpu_mode_register.sub_enable <= pwdata[`CCM_CPU_SUB_EN_BIT];
        end
    end

    // misc control; start bit self-clears when the switch completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc_clock_control_register <=
                clock_control_pkg::misc_control_type'(4'(`CCM_MISC_RESET));
        end else if (write_misc) begin
            misc_clock_control_register <= pwdata[3:0];
        end else if (!low_speed) begin
            misc_clock_control_register.auto_start <= 1'b0;
        end
    end

    // auto switch trigger and delay in low-speed machine cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_pending <= 1'b0;
            auto_count <= 4'h0;
        end else if (!low_speed) begin
            auto_pending <= 1'b0;
        end else if (!auto_pending) begin
            if ((misc_clock_control_register.auto_enable && bus_edge)
                || misc_clock_control_register.auto_start) begin
                auto_pending <= 1'b1;
                auto_count <= misc_clock_control_register.auto_wait_long ?
                    `CCM_AUTO_WAIT_LONG : `CCM_AUTO_WAIT_SHORT;
            end
        end else if (phase_tick && internal_clock && auto_count != 4'h0) begin
            auto_count <= auto_count - 4'h1;
        end
    end

    level_edge_watch #(
        .idle_level(1'b0)
    ) i_level_edge_watch_main (
        .pclk(pclk),
        .presetn(presetn),
        .level(main_oscillator_input),
        .rise(main_edge),
        .change()
    );

    level_edge_watch #(
        .idle_level(1'b0)
    ) i_level_edge_watch_sub (
        .pclk(pclk),
        .presetn(presetn),
        .level(sub_oscillator_input),
        .rise(sub_edge),
        .change()
    );

    level_edge_watch #(
        .idle_level(1'b1)
    ) i_level_edge_watch_scl (
        .pclk(pclk),
        .presetn(presetn),
        .level(scl_in),
        .rise(),
        .change(scl_change)
    );

    level_edge_watch #(
        .idle_level(1'b1)
    ) i_level_edge_watch_sda (
        .pclk(pclk),
        .presetn(presetn),
        .level(sda_in),
        .rise(),
        .change(sda_change)
    );

    // source select and divide ratio
    always_comb begin
        src_edge = main_edge;
        div_ratio = `CCM_DIV_HALF;
        unique case (cpu_mode_register.speed)
            `CCM_SPEED_LOW: src_edge = sub_edge;
            `CCM_SPEED_MIDDLE: div_ratio = `CCM_DIV_MIDDLE;
            default: div_ratio = `CCM_DIV_HALF;
        endcase
    end

    // toggle internal clock every half ratio of source edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 4'h0;
        end else if (src_edge) begin
            if (div_count >= (div_ratio >> 1) - 4'h1) begin
                div_count <= 4'h0;
            end else begin
                div_count <= div_count + 4'h1;
            end
        end
    end
    assign phase_tick = src_edge && div_count >= (div_ratio >> 1) - 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_clock <= 1'b1;
        end else if (state != clock_control_pkg::run_state) begin
            internal_clock <= 1'b1;
        end else if (phase_tick) begin
            internal_clock <= !internal_clock;
        end
    end

    // power state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= clock_control_pkg::run_state;
        end else begin
            unique case (state)
                clock_control_pkg::run_state: begin
                    if (stop_instruction) begin
                        state <= clock_control_pkg::stop_state;
                    end else if (wait_instruction) begin
                        state <= clock_control_pkg::wait_state;
                    end
                end
                clock_control_pkg::wait_state: begin
                    if (interrupt_accepted) begin
                        state <= clock_control_pkg::run_state;
                    end
                end
                clock_control_pkg::stop_state: begin
                    if (external_interrupt) begin
                        state <= clock_control_pkg::release_state;
                    end
                end
                clock_control_pkg::release_state: begin
                    if (underflow) begin
                        state <= clock_control_pkg::run_state;
                    end
                end
            endcase
        end
    end

    // prescaler 12 and timer 1 chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_div <= 5'h00;
            prescaler <= 8'h00;
            timer <= 8'h00;
        end else if (state == clock_control_pkg::run_state && stop_instruction) begin
            if (!misc_clock_control_register.stab_skip) begin
                prescaler <= `CCM_PRESCALER_PRELOAD;
                timer <= `CCM_TIMER_PRELOAD;
            end
        end else if (write_prescaler) begin
            prescaler <= pwdata[7:0];
        end else if (write_timer) begin
            timer <= pwdata[7:0];
        end else if (state == clock_control_pkg::release_state && src_edge) begin
            if (pre_div == `CCM_DIV_PRESCALE - 5'h01) begin
                pre_div <= 5'h00;
                if (prescaler == 8'h00) begin
                    prescaler <= `CCM_PRESCALER_PRELOAD;
                    timer <= timer - 8'h01;
                end else begin
                    prescaler <= prescaler - 8'h01;
                end
            end else begin
                pre_div <= pre_div + 5'h01;
            end
        end
    end

    // oscillator enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_osc_enable <= 1'b1;
            sub_osc_enable <= 1'b0;
            sub_pins_as_port <= 1'b1;
        end else begin
            main_osc_enable <= state != clock_control_pkg::stop_state
                && !(low_speed && cpu_mode_register.main_stop && !auto_pending);
            sub_osc_enable <= state != clock_control_pkg::stop_state
                && cpu_mode_register.sub_enable;
            sub_pins_as_port <= !cpu_mode_register.sub_enable;
        end
    end

endmodule

// registered copy of a level pin and its edges
module level_edge_watch #(
    parameter logic idle_level = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // watched pin
    input wire logic level,
    // edges seen this cycle
    output logic rise,
    output logic change
);

    logic level_d;

    // reset to the idle level so no false edge follows reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_d <= idle_level;
        end else begin
            level_d <= level;
        end
    end

    assign rise = level && !level_d;
    assign change = level != level_d;

endmodule

/* sim/system_clock_mode_and_power_control_monitor.sv */
module system_clock_mode_and_power_control_monitor (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // cpu events
    input wire logic wait_instruction,
    input wire logic interrupt_accepted,
    input wire logic external_interrupt,
    // clock and oscillator control
    input wire logic internal_clock,
    input wire logic main_osc_enable,
    input wire logic sub_osc_enable,
    input wire logic sub_pins_as_port
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmapped: assert property (psel && !penable && paddr > 12'h010 |=> pslverr)
        else $error("unmapped access not refused");
    a_reset_state: assert property ($rose(presetn) |->
        main_osc_enable && !sub_osc_enable && sub_pins_as_port && internal_clock)
        else $error("wrong oscillator state after reset");
    a_sub_pins: assert property (sub_osc_enable |-> !sub_pins_as_port)
        else $error("sub pins still port while sub runs");
    a_stop_high: assert property (!main_osc_enable && !sub_osc_enable |-> internal_clock)
        else $error("clock low with both oscillators off");
    a_wait_gate: assert property (wait_instruction && main_osc_enable
        ##1 (!interrupt_accepted) [*4] |-> internal_clock)
        else $error("clock not held high in wait");
    a_wait_osc: assert property (wait_instruction && main_osc_enable
        |=> main_osc_enable [*3])
        else $error("oscillator stopped by wait");
    a_release_hold: assert property (external_interrupt && !main_osc_enable
        && !sub_osc_enable |=> internal_clock [*8])
        else $error("clock supplied too early after stop");
    a_restart_osc: assert property (external_interrupt && !main_osc_enable
        && !sub_osc_enable |-> ##[1:3] (main_osc_enable || sub_osc_enable))
        else $error("oscillator not restarted by interrupt");
endmodule

bind system_clock_mode_and_power_control system_clock_mode_and_power_control_monitor i_mon (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .wait_instruction,
    .interrupt_accepted, .external_interrupt, .internal_clock, .main_osc_enable,
    .sub_osc_enable, .sub_pins_as_port
);

/* sim/tb_system_clock_mode_and_power_control.sv */
module tb_system_clock_mode_and_power_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, prev;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, internal_clock, main_osc_enable, sub_osc_enable, sub_pins_as_port;
    logic main_oscillator_input = 0, sub_oscillator_input = 0, stop_instruction = 0;
    logic wait_instruction = 0, interrupt_accepted = 0, external_interrupt = 0;
    logic scl_in = 1, sda_in = 1;
    logic [2:0] div = 3'h0;
    int mismatches = 0, n_tests = 0, cyc = 0, n;

    system_clock_mode_and_power_control i_system_clock_mode_and_power_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .main_oscillator_input, .sub_oscillator_input, .stop_instruction,
        .wait_instruction, .interrupt_accepted, .external_interrupt, .scl_in, .sda_in,
        .internal_clock, .main_osc_enable, .sub_osc_enable, .sub_pins_as_port
    );

    always #12.5 pclk = ~pclk;

    // main at pclk/2, sub at pclk/16, ratio well above three
    always @(posedge pclk) begin
        main_oscillator_input <= ~main_oscillator_input;
        div <= div + 3'h1;
        if (div == 3'h7) sub_oscillator_input <= ~sub_oscillator_input;
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(q, e);
    endtask

    // rising edges of the internal clock over 320 pclk cycles
    task rate(input int e);
        n = 0;
        prev = internal_clock;
        repeat (320) begin
            @(posedge pclk);
            if (internal_clock === 1'b1 && prev === 1'b0) n++;
            prev = internal_clock;
        end
        check(32'(n >= e - 1 && n <= e + 1), 32'h1);
    endtask

    task wait_run(input int lim);
        n = 0;
        while (internal_clock !== 1'b0 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 32'h80);
        rd(12'h004, 32'h00);
        check({29'h0, main_osc_enable, sub_osc_enable, sub_pins_as_port}, 32'h5);
        rd(12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 12'h008, 32'h3);
        rd(12'h008, 32'h0);
        rate(20);
        apb(1'b1, 12'h000, 32'h90);
        repeat (2) @(posedge pclk);
        check({30'h0, sub_osc_enable, sub_pins_as_port}, 32'h2);
        apb(1'b1, 12'h000, 32'h10);
        rate(80);
        apb(1'b1, 12'h000, 32'h50);
        rate(10);
        apb(1'b1, 12'h000, 32'h70);
        repeat (2) @(posedge pclk);
        check({31'h0, main_osc_enable}, 32'h0);
        apb(1'b1, 12'h000, 32'h50);
        repeat (20) @(posedge pclk);
        check({31'h0, main_osc_enable}, 32'h1);
        // start bit, short delay
        apb(1'b1, 12'h004, 32'h08);
        repeat (100) @(posedge pclk);
        rd(12'h000, 32'h50);
        repeat (300) @(posedge pclk);
        rd(12'h000, 32'h90);
        rd(12'h004, 32'h00);
        // bus edges, long delay, main stopped beforehand
        apb(1'b1, 12'h000, 32'h70);
        apb(1'b1, 12'h004, 32'h06);
        @(posedge pclk) scl_in <= 1'b0;
        repeat (180) @(posedge pclk);
        rd(12'h000, 32'h70);
        repeat (300) @(posedge pclk);
        rd(12'h000, 32'h90);
        check({31'h0, main_osc_enable}, 32'h1);
        apb(1'b1, 12'h000, 32'h50);
        @(posedge pclk) sda_in <= 1'b0;
        repeat (400) @(posedge pclk);
        rd(12'h000, 32'h90);
        apb(1'b1, 12'h004, 32'h00);
        // wait mode
        @(posedge pclk) wait_instruction <= 1'b1;
        @(posedge pclk) wait_instruction <= 1'b0;
        repeat (20) @(posedge pclk);
        check({31'h0, internal_clock}, 32'h1);
        rd(12'h008, 32'h1);
        @(posedge pclk) interrupt_accepted <= 1'b1;
        @(posedge pclk) interrupt_accepted <= 1'b0;
        rate(20);
        // stop mode with full stabilizing wait
        @(posedge pclk) stop_instruction <= 1'b1;
        @(posedge pclk) stop_instruction <= 1'b0;
        repeat (4) @(posedge pclk);
        check({29'h0, main_osc_enable, sub_osc_enable, internal_clock}, 32'h1);
        rd(12'h00c, 32'hff);
        rd(12'h010, 32'h01);
        rd(12'h008, 32'h2);
        @(posedge pclk) external_interrupt <= 1'b1;
        @(posedge pclk) external_interrupt <= 1'b0;
        repeat (3) @(posedge pclk);
        check({31'h0, main_osc_enable}, 32'h1);
        wait_run(20000);
        check(32'(n >= 16300 && n <= 16400), 32'h1);
        rd(12'h008, 32'h0);
        // stop mode with software preload
        apb(1'b1, 12'h004, 32'h01);
        apb(1'b1, 12'h00c, 32'h03);
        apb(1'b1, 12'h010, 32'h00);
        @(posedge pclk) stop_instruction <= 1'b1;
        @(posedge pclk) stop_instruction <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(12'h00c, 32'h03);
        rd(12'h010, 32'h00);
        @(posedge pclk) external_interrupt <= 1'b1;
        @(posedge pclk) external_interrupt <= 1'b0;
        wait_run(2000);
        check(32'(n < 2000), 32'h1);
        print_verdict();
    end
endmodule
